// file: shared/sio_pkg.sv
// How it works
// - Command 12h/00h returns input device bitmap.
// - Input bits 0-15,18,20,22,23,26-29 assigned devices.
// - Command 12h/40h returns input pins 0-11.
// - Pulse train selected: pin bits 10,11 read 0.
// - Command 12h/60h returns communication-driven input devices.
// - Command 12h/C0h returns output pins 0-8.
// - Command 12h/80h returns output device bitmap.
// - Output bitmap bits follow the fixed device order.
// - Every returned bitmap is sent as hex text.
// - Command 92h/60h overwrites all communication input devices.
// - Command 90h 00h/10h with key gates inputs.
// - Disabled inputs read off; stop and limits stay.
// - Command 90h 03h/13h with key gates outputs.
// - Test mode: 92h/00h switches test input devices.
// - Test entry allowed anytime; power stage shuts off.
// - Test mode silence 0.5 s: decelerate, servo lock.
// - Command 8Bh/00h selects jog, positioning, forced output.
// - Command 00h/12h returns current test mode code.
// - Command 8Bh/00h with 0000 cancels test mode.
package sio_pkg;
    // Command codes and data numbers.
    localparam logic [7:0]  CMD_MODE_RD   = 8'h00;
    localparam logic [7:0]  CMD_DEV_RD    = 8'h12;
    localparam logic [7:0]  CMD_TEST_SEL  = 8'h8b;
    localparam logic [7:0]  CMD_IO_GATE   = 8'h90;
    localparam logic [7:0]  CMD_DEV_WR    = 8'h92;
    localparam logic [7:0]  DN_IN_DEV     = 8'h00;
    localparam logic [7:0]  DN_IN_PIN     = 8'h40;
    localparam logic [7:0]  DN_COMM_IN    = 8'h60;
    localparam logic [7:0]  DN_OUT_DEV    = 8'h80;
    localparam logic [7:0]  DN_OUT_PIN    = 8'hc0;
    localparam logic [7:0]  DN_MODE       = 8'h12;
    localparam logic [7:0]  DN_TEST       = 8'h00;
    localparam logic [7:0]  DN_IN_OFF     = 8'h00;
    localparam logic [7:0]  DN_IN_ON      = 8'h10;
    localparam logic [7:0]  DN_OUT_OFF    = 8'h03;
    localparam logic [7:0]  DN_OUT_ON     = 8'h13;
    localparam logic [15:0] GATE_KEY      = 16'h1ea5;
    // Test mode codes as carried in the data word.
    localparam logic [15:0] MODE_NORMAL   = 16'h0000;
    localparam logic [15:0] MODE_JOG      = 16'h0001;
    localparam logic [15:0] MODE_POS      = 16'h0002;
    localparam logic [15:0] MODE_DO       = 16'h0004;
    // Assigned bit masks of each bitmap; all other bits read zero.
    localparam logic [31:0] IN_DEV_MASK   = 32'h3cd4ffff;
    localparam logic [31:0] OUT_DEV_MASK  = 32'h8f208fbf;
    localparam logic [31:0] IN_PIN_MASK   = 32'h00000fff;
    localparam logic [31:0] OUT_PIN_MASK  = 32'h000001ff;
    // Pulse train pins and devices that cannot be disabled.
    localparam logic [31:0] PULSE_PIN_MASK = 32'h00000c00;
    localparam logic [31:0] KEEP_MASK     = 32'h00040006;
    // Reset values.
    localparam logic [31:0] RST_BITMAP    = 32'h00000000;
    // Silence time before the test stop, and the clock rate.
    localparam int          SILENCE_MS    = 500;
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          SILENCE_CYC   = SILENCE_MS * (CLK_HZ / 1000);
    localparam int          SYNC_DEPTH    = 3;

    typedef enum logic [1:0] {SIO_NORMAL, SIO_JOG, SIO_POS, SIO_DO} sio_mode_e;
endpackage : sio_pkg

// file: rtl/sio_cmd.sv
`timescale 1ns/10ps
`default_nettype none
module sio_cmd
    import sio_pkg::*;
#(
    parameter int SILENCE_LIMIT = SILENCE_CYC
)
(
    input  wire logic        clk_sys_in,        // System clock, 10 MHz.
    input  wire logic        rst_n_in,          // Asynchronous reset, active low.
    input  wire logic        cmd_valid_in,      // One-cycle strobe of a decoded command.
    input  wire logic [7:0]  cmd_code_in,       // Command code.
    input  wire logic [7:0]  cmd_dnum_in,       // Data number.
    input  wire logic [31:0] cmd_data_in,       // Data word of a write command.
    input  wire logic [31:0] ext_in_dev_in,     // External input devices, asynchronous.
    input  wire logic [11:0] ext_in_pin_in,     // External input pins, asynchronous.
    input  wire logic [31:0] out_dev_in,        // Output devices from servo logic.
    input  wire logic [8:0]  out_pin_in,        // External output pin states.
    input  wire logic        pulse_input_sel_param_a_in, // Pulse train selected on pin set A.
    input  wire logic        pulse_input_sel_param_b_in, // Pulse train selected on pin set B.
    output logic             resp_valid_out,    // One-cycle answer strobe.
    output logic [31:0]      resp_data_out,     // Answer bitmap, binary.
    output logic [63:0]      resp_hex_out,      // Answer as eight hex characters.
    output logic             cmd_ack_out,       // Write command accepted.
    output logic             cmd_err_out,       // Command refused.
    output logic [31:0]      eff_in_dev_out,    // Input devices seen by the servo.
    output logic [31:0]      out_dev_gated_out, // Output devices after gating.
    output logic             in_disabled_out,   // Inputs are disabled.
    output logic             out_disabled_out,  // Outputs are disabled.
    output logic             analog_zero_out,   // Analog inputs forced to 0 V.
    output logic             pulse_block_out,   // Pulse train input treated as absent.
    output logic [15:0]      test_code_out,     // Current test mode code.
    output logic             coast_out,         // Power stage shut off.
    output logic             stop_lock_out      // Decelerate to stop, servo lock.
);

    // Converts one nibble to its upper-case hex character.
    function automatic logic [7:0] nib_to_ascii(input logic [3:0] nib);
        logic [7:0] ch;
        ch = (nib < 4'ha) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
        return ch;
    endfunction : nib_to_ascii

    // Converts a bitmap to eight hex characters, most significant first.
    function automatic logic [63:0] word_to_hex(input logic [31:0] w);
        logic [63:0] s;
        s = '0;
        for (int i = 0; i < 8; i++)
        begin
            s[i*8 +: 8] = nib_to_ascii(w[i*4 +: 4]);
        end
        return s;
    endfunction : word_to_hex

    // Maps a mode to its data-word code.
    function automatic logic [15:0] mode_code(input sio_mode_e m);
        logic [15:0] c;
        unique case (m)
            SIO_NORMAL: c = MODE_NORMAL;
            SIO_JOG:    c = MODE_JOG;
            SIO_POS:    c = MODE_POS;
            SIO_DO:     c = MODE_DO;
        endcase
        return c;
    endfunction : mode_code

    // Synchroniser stages for the asynchronous inputs.
    logic [43:0] sync1_r;
    logic [43:0] sync2_r;
    logic [43:0] sync3_r;
    logic [43:0] filt_r;
    logic [43:0] filt_nxt;

    // Control state.
    sio_mode_e   mode_r;
    sio_mode_e   mode_nxt;
    logic [31:0] comm_in_r;
    logic [31:0] comm_in_nxt;
    logic [31:0] test_in_r;
    logic [31:0] test_in_nxt;
    logic        in_dis_r;
    logic        in_dis_nxt;
    logic        out_dis_r;
    logic        out_dis_nxt;
    logic        coast_r;
    logic        coast_nxt;
    logic        lock_r;
    logic        lock_nxt;
    logic [22:0] silence_r;
    logic [22:0] silence_nxt;

    // Answer and derived outputs.
    logic        resp_valid_r;
    logic        resp_valid_nxt;
    logic [31:0] resp_data_r;
    logic [31:0] resp_data_nxt;
    logic        ack_r;
    logic        ack_nxt;
    logic        err_r;
    logic        err_nxt;
    logic [31:0] eff_r;
    logic [31:0] eff_nxt;
    logic [31:0] out_gate_r;
    logic [31:0] out_gate_nxt;

    logic        pulse_sel;
    logic        key_ok;
    logic [31:0] in_pin_map;

    // Three stages; a bit counts once stages two and three agree.
    always_comb
    begin
        filt_nxt = (sync2_r & ~(sync2_r ^ sync3_r)) | (filt_r & (sync2_r ^ sync3_r));
    end

    // Registers the synchroniser chain.
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            filt_r  <= '0;
        end
        else
        begin
            sync1_r <= {ext_in_pin_in, ext_in_dev_in};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            filt_r  <= filt_nxt;
        end
    end

    // Input pin bitmap; pulse train pins read off when selected.
    assign pulse_sel  = pulse_input_sel_param_a_in | pulse_input_sel_param_b_in;
    assign in_pin_map = {20'h00000, filt_r[43:32]}
                        & (pulse_sel ? (IN_PIN_MASK & ~PULSE_PIN_MASK) : IN_PIN_MASK);
    assign key_ok     = (cmd_data_in[15:0] == GATE_KEY);

    // Command decode: control state, answers and the silence watchdog.
    always_comb
    begin
        mode_nxt       = mode_r;
        comm_in_nxt    = comm_in_r;
        test_in_nxt    = test_in_r;
        in_dis_nxt     = in_dis_r;
        out_dis_nxt    = out_dis_r;
        coast_nxt      = coast_r;
        lock_nxt       = lock_r;
        silence_nxt    = silence_r;
        resp_valid_nxt = 1'b0;
        resp_data_nxt  = resp_data_r;
        ack_nxt        = 1'b0;
        err_nxt        = 1'b0;
        if (cmd_valid_in)
        begin
            if (cmd_code_in == CMD_DEV_RD)
            begin
                resp_valid_nxt = 1'b1;
                unique case (cmd_dnum_in)
                    DN_IN_DEV:  resp_data_nxt = eff_r & IN_DEV_MASK;
                    DN_IN_PIN:  resp_data_nxt = in_pin_map;
                    DN_COMM_IN: resp_data_nxt = comm_in_r & IN_DEV_MASK;
                    DN_OUT_DEV: resp_data_nxt = out_gate_r & OUT_DEV_MASK;
                    DN_OUT_PIN: resp_data_nxt = {23'h000000, out_pin_in}
                                                & OUT_PIN_MASK;
                    default:
                    begin
                        resp_valid_nxt = 1'b0;
                        err_nxt        = 1'b1;
                    end
                endcase
            end
            else if (cmd_code_in == CMD_MODE_RD && cmd_dnum_in == DN_MODE)
            begin
                resp_valid_nxt = 1'b1;
                resp_data_nxt  = {16'h0000, mode_code(mode_r)};
            end
            else if (cmd_code_in == CMD_DEV_WR && cmd_dnum_in == DN_COMM_IN)
            begin
                comm_in_nxt = cmd_data_in & IN_DEV_MASK;
                ack_nxt     = 1'b1;
            end
            else if (cmd_code_in == CMD_DEV_WR && cmd_dnum_in == DN_TEST
                     && mode_r != SIO_NORMAL)
            begin
                test_in_nxt = cmd_data_in & IN_DEV_MASK;
                ack_nxt     = 1'b1;
            end
            else if (cmd_code_in == CMD_IO_GATE && key_ok
                     && (cmd_dnum_in == DN_IN_OFF || cmd_dnum_in == DN_IN_ON))
            begin
                in_dis_nxt = (cmd_dnum_in == DN_IN_OFF);
                ack_nxt    = 1'b1;
            end
            else if (cmd_code_in == CMD_IO_GATE && key_ok
                     && (cmd_dnum_in == DN_OUT_OFF || cmd_dnum_in == DN_OUT_ON))
            begin
                out_dis_nxt = (cmd_dnum_in == DN_OUT_OFF);
                ack_nxt     = 1'b1;
            end
            else if (cmd_code_in == CMD_TEST_SEL && cmd_dnum_in == DN_TEST
                     && cmd_data_in[31:16] == 16'h0000)
            begin
                ack_nxt = 1'b1;
                unique case (cmd_data_in[15:0])
                    MODE_JOG: mode_nxt = SIO_JOG;
                    MODE_POS: mode_nxt = SIO_POS;
                    MODE_DO:  mode_nxt = SIO_DO;
                    MODE_NORMAL:
                    begin
                        mode_nxt    = SIO_NORMAL;
                        test_in_nxt = RST_BITMAP;
                    end
                    default:
                    begin
                        ack_nxt = 1'b0;
                        err_nxt = 1'b1;
                    end
                endcase
            end
            else
            begin
                err_nxt = 1'b1;
            end
        end
        // Entry into test mode coasts the motor, even while running.
        coast_nxt = (mode_nxt != SIO_NORMAL);
        // Silence watchdog; any command restarts it and releases the lock.
        if (mode_nxt == SIO_NORMAL || cmd_valid_in)
        begin
            silence_nxt = '0;
            lock_nxt    = 1'b0;
        end
        else if (silence_r >= 23'(SILENCE_LIMIT - 1))
        begin
            lock_nxt = 1'b1;
        end
        else
        begin
            silence_nxt = silence_r + 23'h000001;
        end
        // Disabled inputs read off except the stop and stroke limits.
        eff_nxt = (filt_r[31:0] | comm_in_r | (mode_r != SIO_NORMAL ? test_in_r : 32'h0))
                  & (in_dis_r ? KEEP_MASK : IN_DEV_MASK);
        out_gate_nxt = out_dis_r ? RST_BITMAP : (out_dev_in & OUT_DEV_MASK);
    end

    // Registers the control state and answers.
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mode_r       <= SIO_NORMAL;
            comm_in_r    <= RST_BITMAP;
            test_in_r    <= RST_BITMAP;
            in_dis_r     <= 1'b0;
            out_dis_r    <= 1'b0;
            coast_r      <= 1'b0;
            lock_r       <= 1'b0;
            silence_r    <= '0;
            resp_valid_r <= 1'b0;
            resp_data_r  <= RST_BITMAP;
            ack_r        <= 1'b0;
            err_r        <= 1'b0;
            eff_r        <= RST_BITMAP;
            out_gate_r   <= RST_BITMAP;
        end
        else
        begin
            mode_r       <= mode_nxt;
            comm_in_r    <= comm_in_nxt;
            test_in_r    <= test_in_nxt;
            in_dis_r     <= in_dis_nxt;
            out_dis_r    <= out_dis_nxt;
            coast_r      <= coast_nxt;
            lock_r       <= lock_nxt;
            silence_r    <= silence_nxt;
            resp_valid_r <= resp_valid_nxt;
            resp_data_r  <= resp_data_nxt;
            ack_r        <= ack_nxt;
            err_r        <= err_nxt;
            eff_r        <= eff_nxt;
            out_gate_r   <= out_gate_nxt;
        end
    end

    // Output drive; the hex text is formed from the registered bitmap.
    assign resp_valid_out    = resp_valid_r;
    assign resp_data_out     = resp_data_r;
    assign resp_hex_out      = word_to_hex(resp_data_r);
    assign cmd_ack_out       = ack_r;
    assign cmd_err_out       = err_r;
    assign eff_in_dev_out    = eff_r;
    assign out_dev_gated_out = out_gate_r;
    assign in_disabled_out   = in_dis_r;
    assign out_disabled_out  = out_dis_r;
    assign analog_zero_out   = in_dis_r;
    assign pulse_block_out   = in_dis_r;
    assign test_code_out     = mode_code(mode_r);
    assign coast_out         = coast_r;
    assign stop_lock_out     = lock_r;

    // Checks on the command behaviour.
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_rd(logic [7:0] dn);
        cmd_valid_in && cmd_code_in == CMD_DEV_RD && cmd_dnum_in == dn;
    endsequence

    property p_in_dev_read;
        s_rd(DN_IN_DEV) |=> resp_valid_out && resp_data_out == ($past(eff_r) & IN_DEV_MASK);
    endproperty
    a_in_dev_read: assert property (p_in_dev_read) else $error("Input bitmap wrong.");

    property p_pulse_pins;
        cmd_valid_in && cmd_code_in == CMD_DEV_RD && cmd_dnum_in == DN_IN_PIN && pulse_sel
        |=> resp_data_out[11:10] == 2'b00 && resp_data_out[31:12] == 20'h00000;
    endproperty
    a_pulse_pins: assert property (p_pulse_pins) else $error("Pulse pins not off.");

    property p_out_pin_read;
        s_rd(DN_OUT_PIN) |=> resp_data_out == {23'h000000, $past(out_pin_in)};
    endproperty
    a_out_pin_read: assert property (p_out_pin_read) else $error("Output pins wrong.");

    property p_hex_text;
        resp_valid_out |-> resp_hex_out[63:56] == nib_to_ascii(resp_data_out[31:28])
                           && resp_hex_out[7:0] == nib_to_ascii(resp_data_out[3:0]);
    endproperty
    a_hex_text: assert property (p_hex_text) else $error("Hex text mismatch.");

    property p_comm_write;
        cmd_valid_in && cmd_code_in == CMD_DEV_WR && cmd_dnum_in == DN_COMM_IN
        |=> comm_in_r == ($past(cmd_data_in) & IN_DEV_MASK);
    endproperty
    a_comm_write: assert property (p_comm_write) else $error("Comm write lost.");

    property p_in_disabled;
        in_disabled_out |=> (eff_in_dev_out & ~KEEP_MASK) == 32'h0;
    endproperty
    a_in_disabled: assert property (p_in_disabled) else $error("Disabled input on.");

    property p_out_disabled;
        cmd_valid_in && cmd_code_in == CMD_IO_GATE && cmd_dnum_in == DN_OUT_OFF
        && cmd_data_in[15:0] == GATE_KEY |=> out_disabled_out ##1 out_dev_gated_out == 32'h0;
    endproperty
    a_out_disabled: assert property (p_out_disabled) else $error("Outputs not gated.");

    property p_coast_entry;
        cmd_valid_in && cmd_code_in == CMD_TEST_SEL && cmd_dnum_in == DN_TEST
        && cmd_data_in == 32'h00000001 |=> coast_out && test_code_out == MODE_JOG;
    endproperty
    a_coast_entry: assert property (p_coast_entry) else $error("No coast on entry.");

    property p_silence_lock;
        coast_out && !cmd_valid_in && silence_r >= 23'(SILENCE_LIMIT - 1) |=> stop_lock_out;
    endproperty
    a_silence_lock: assert property (p_silence_lock) else $error("No stop on silence.");

    property p_cancel;
        cmd_valid_in && cmd_code_in == CMD_TEST_SEL && cmd_dnum_in == DN_TEST
        && cmd_data_in == 32'h00000000 |=> !coast_out && test_code_out == MODE_NORMAL
                                            && !stop_lock_out;
    endproperty
    a_cancel: assert property (p_cancel) else $error("Cancel failed.");

    c_out_read:  cover property (s_rd(DN_OUT_DEV) ##1 resp_valid_out);
    c_test_lock: cover property (coast_out ##1 stop_lock_out);
    c_in_gate:   cover property (in_disabled_out ##1 !in_disabled_out);

endmodule : sio_cmd
`default_nettype wire

// file: dv/sio_master.sv
`timescale 1ns/10ps
`default_nettype none
// Master station model: sends one command per call and collects the answer.
module sio_master
(
    input  wire logic        clk_in,        // System clock.
    input  wire logic        resp_valid_in, // Read answer strobe.
    input  wire logic        ack_in,        // Accept strobe.
    input  wire logic        err_in,        // Refusal strobe.
    input  wire logic [31:0] resp_data_in,  // Answer bitmap.
    output logic             valid_out,     // Command strobe.
    output logic [7:0]       code_out,      // Command code.
    output logic [7:0]       dnum_out,      // Data number.
    output logic [31:0]      data_out       // Data word.
);
    // Lines start idle so the design sees no command before reset ends.
    initial
    begin
        valid_out = 1'b0;
        code_out = 8'hff;
        dnum_out = 8'hff;
        data_out = 32'hffffffff;
    end

    // One command; kind is 0 none, 1 read answer, 2 accept, 3 refusal.
    task automatic xfer(input logic [7:0] c, input logic [7:0] d, input logic [31:0] w,
                        output logic [1:0] kind, output logic [31:0] rdata);
        kind = 2'd0;
        rdata = 32'h0;
        @(negedge clk_in);
        valid_out = 1'b1;
        code_out = c;
        dnum_out = d;
        data_out = w;
        @(negedge clk_in);
        // Released lines show the inverse, so a design reading them late is caught.
        valid_out = 1'b0;
        code_out = ~c;
        dnum_out = ~d;
        data_out = ~w;
        // The answer strobe stands for one cycle after the take edge, so look mid-cycle.
        for (int i = 0; i < 4 && kind == 2'd0; i++)
        begin
            if (i > 0) @(negedge clk_in);
            if (resp_valid_in === 1'b1) kind = 2'd1;
            else if (ack_in === 1'b1) kind = 2'd2;
            else if (err_in === 1'b1) kind = 2'd3;
            rdata = resp_data_in;
        end
    endtask : xfer
endmodule : sio_master
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import sio_pkg::*;
    localparam int SIL = 20;
    logic        clk_sys_in, rst_n_in, cmd_valid, resp_valid, ack, err;
    logic        pa, pb, in_dis, out_dis, az, pblk, coast, lock;
    logic [7:0]  code, dnum;
    logic [31:0] data, ext_dev, out_dev, resp_data, eff, gated;
    logic [11:0] ext_pin;
    logic [8:0]  out_pin;
    logic [63:0] hex;
    logic [15:0] tcode;
    int          n_errors, checks_done;

    sio_cmd #(.SILENCE_LIMIT(SIL)) dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .cmd_valid_in(cmd_valid), .cmd_code_in(code), .cmd_dnum_in(dnum), .cmd_data_in(data),
        .ext_in_dev_in(ext_dev), .ext_in_pin_in(ext_pin), .out_dev_in(out_dev),
        .out_pin_in(out_pin), .pulse_input_sel_param_a_in(pa), .pulse_input_sel_param_b_in(pb),
        .resp_valid_out(resp_valid), .resp_data_out(resp_data), .resp_hex_out(hex),
        .cmd_ack_out(ack), .cmd_err_out(err), .eff_in_dev_out(eff),
        .out_dev_gated_out(gated), .in_disabled_out(in_dis), .out_disabled_out(out_dis),
        .analog_zero_out(az), .pulse_block_out(pblk), .test_code_out(tcode),
        .coast_out(coast), .stop_lock_out(lock));
    sio_master m_u (.clk_in(clk_sys_in), .resp_valid_in(resp_valid), .ack_in(ack),
        .err_in(err), .resp_data_in(resp_data), .valid_out(cmd_valid), .code_out(code),
        .dnum_out(dnum), .data_out(data));

    // Clock of 100 ns period.
    initial
    begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    // Counts one comparison and reports a mismatch.
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    // Upper-case hex text of a bitmap, top nibble first.
    function automatic logic [63:0] hex8(input logic [31:0] v);
        logic [3:0] n;
        for (int i = 0; i < 8; i++)
        begin
            n = v[i*4 +: 4];
            hex8[i*8 +: 8] = (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
        end
    endfunction : hex8

    // Sends a command and checks the kind of answer and any read data with its text.
    task automatic cmd(input logic [7:0] c, input logic [7:0] d, input logic [31:0] w,
                       input logic [1:0] ek, input logic [31:0] ed);
        logic [1:0]  k;
        logic [31:0] r;
        m_u.xfer(c, d, w, k, r);
        if (k == 2'd0)
        begin
            n_errors++;
            complete_run();
        end
        chk(k, ek);
        if (ek == 2'd1)
        begin
            chk(r, ed);
            chk(hex, hex8(ed));
        end
    endtask : cmd

    // Reads of input devices and input pins, with both pulse selections.
    task automatic t_in_read();
        ext_dev = 32'hffffffff;
        ext_pin = 12'hfff;
        repeat (6) @(negedge clk_sys_in);
        cmd(CMD_DEV_RD, DN_IN_DEV, 32'h0, 2'd1, IN_DEV_MASK);
        cmd(CMD_DEV_RD, DN_IN_PIN, 32'h0, 2'd1, 32'h00000fff);
        pa = 1'b1;
        cmd(CMD_DEV_RD, DN_IN_PIN, 32'h0, 2'd1, 32'h000003ff);
        pa = 1'b0;
        pb = 1'b1;
        cmd(CMD_DEV_RD, DN_IN_PIN, 32'h0, 2'd1, 32'h000003ff);
        pb = 1'b0;
        cmd(CMD_DEV_RD, 8'h20, 32'h0, 2'd3, 32'h0);
        $display("test in_read done");
    endtask : t_in_read

    // Communication device writes overwrite earlier states.
    task automatic t_comm();
        ext_dev = 32'h0;
        repeat (6) @(negedge clk_sys_in);
        cmd(CMD_DEV_WR, DN_COMM_IN, 32'hffffffff, 2'd2, 32'h0);
        cmd(CMD_DEV_RD, DN_COMM_IN, 32'h0, 2'd1, IN_DEV_MASK);
        cmd(CMD_DEV_WR, DN_COMM_IN, 32'h00000001, 2'd2, 32'h0);
        cmd(CMD_DEV_RD, DN_COMM_IN, 32'h0, 2'd1, 32'h00000001);
        cmd(CMD_DEV_RD, DN_IN_DEV, 32'h0, 2'd1, 32'h00000001);
        cmd(CMD_DEV_WR, DN_COMM_IN, 32'h0, 2'd2, 32'h0);
        $display("test comm done");
    endtask : t_comm

    // Output reads and output gating with a wrong and a right key.
    task automatic t_out();
        out_dev = 32'hffffffff;
        out_pin = 9'h1ff;
        cmd(CMD_DEV_RD, DN_OUT_DEV, 32'h0, 2'd1, OUT_DEV_MASK);
        cmd(CMD_DEV_RD, DN_OUT_PIN, 32'h0, 2'd1, OUT_PIN_MASK);
        cmd(CMD_IO_GATE, DN_OUT_OFF, {16'h0, GATE_KEY}, 2'd2, 32'h0);
        @(negedge clk_sys_in);
        chk({out_dis, gated}, {1'b1, 32'h0});
        cmd(CMD_DEV_RD, DN_OUT_DEV, 32'h0, 2'd1, 32'h0);
        cmd(CMD_IO_GATE, DN_OUT_ON, 32'h00001ea4, 2'd3, 32'h0);
        cmd(CMD_IO_GATE, DN_OUT_ON, {16'h0, GATE_KEY}, 2'd2, 32'h0);
        cmd(CMD_DEV_RD, DN_OUT_DEV, 32'h0, 2'd1, OUT_DEV_MASK);
        $display("test out done");
    endtask : t_out

    // Input gating keeps only the stop and stroke limit slots.
    task automatic t_in_gate();
        ext_dev = IN_DEV_MASK;
        repeat (6) @(negedge clk_sys_in);
        cmd(CMD_IO_GATE, DN_IN_OFF, {16'h0, GATE_KEY}, 2'd2, 32'h0);
        repeat (2) @(negedge clk_sys_in);
        chk(eff, IN_DEV_MASK & KEEP_MASK);
        chk({in_dis, az, pblk}, 3'b111);
        cmd(CMD_IO_GATE, DN_IN_ON, {16'h0, GATE_KEY}, 2'd2, 32'h0);
        repeat (2) @(negedge clk_sys_in);
        chk({in_dis, az, pblk, eff}, {3'b000, IN_DEV_MASK});
        ext_dev = 32'h0;
        $display("test in_gate done");
    endtask : t_in_gate

    // Test mode select, read back, test inputs, silence stop and cancel.
    task automatic t_test();
        logic [15:0] m [3] = '{MODE_JOG, MODE_POS, MODE_DO};
        cmd(CMD_DEV_WR, DN_IN_DEV, 32'h1, 2'd3, 32'h0);
        foreach (m[i])
        begin
            cmd(CMD_TEST_SEL, DN_TEST, {16'h0, m[i]}, 2'd2, 32'h0);
            chk({coast, tcode}, {1'b1, m[i]});
            cmd(CMD_MODE_RD, DN_MODE, 32'h0, 2'd1, {16'h0, m[i]});
        end
        cmd(CMD_DEV_WR, DN_IN_DEV, 32'h00000100, 2'd2, 32'h0);
        repeat (2) @(negedge clk_sys_in);
        chk(eff, 32'h00000100);
        repeat (15) @(negedge clk_sys_in);
        chk(lock, 1'b0);
        repeat (5) @(negedge clk_sys_in);
        chk(lock, 1'b1);
        cmd(CMD_TEST_SEL, DN_TEST, 32'h3, 2'd3, 32'h0);
        cmd(CMD_TEST_SEL, DN_TEST, 32'h0, 2'd2, 32'h0);
        chk({coast, tcode}, 17'h0);
        cmd(CMD_MODE_RD, DN_MODE, 32'h0, 2'd1, 32'h0);
        $display("test test_mode done");
    endtask : t_test

    // Main sequence: reset, then each scenario in turn.
    initial
    begin
        n_errors = 0;
        checks_done = 0;
        rst_n_in = 1'b0;
        {pa, pb} = 2'b00;
        ext_dev = 32'h0;
        ext_pin = 12'h0;
        out_dev = 32'h0;
        out_pin = 9'h0;
        repeat (4) @(negedge clk_sys_in);
        chk(hex, 64'h3030303030303030);
        chk({tcode, coast}, 17'h0);
        rst_n_in = 1'b1;
        t_in_read();
        t_comm();
        t_out();
        t_in_gate();
        t_test();
        complete_run();
    end
endmodule : tb
`default_nettype wire
